// ### core/eis_pkg.sv
// Purpose: shared constants and types of the external interrupt sense block
// Assumes: 32-bit AXI4-Lite register bus, one clock at 40 MHz
// Notes: byte offsets, bit positions and reset values live here only
`default_nettype none

package eis_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int WDT_PERIOD_NS = 1000;
  localparam int CNT_W = 12;
  localparam int WAKE_SAMPLES = 2;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_MCU_CTL = 8'h00;
  localparam logic [7:0] OFF_EN_CTL = 8'h04;
  localparam logic [7:0] OFF_FLAGS = 8'h08;
  localparam logic [7:0] OFF_IST = 8'h0C;
  localparam logic [7:0] OFF_ICLR = 8'h10;
  localparam logic [7:0] OFF_IEN = 8'h14;
  localparam logic [7:0] OFF_PIN_STATE = 8'h18;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int SENSE_P0_LSB = 0;
  localparam int SENSE_P1_LSB = 2;
  localparam int EN_P0_BIT = 6;
  localparam int FLAG_P0_BIT = 6;
  localparam int EV_P0 = 0;
  localparam int EV_WAKE = 2;
  localparam int EV_W = 3;
  localparam int PST_PIN_LSB = 0;
  localparam int PST_WAKE_BIT = 4;
  localparam int PST_WK_LSB = 5;

  // ----------------------------------------------------------------
  // reset values and responses
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MCU_CTL = 8'h00;
  localparam logic [1:0] RST_EN = 2'h0;
  localparam logic [EV_W-1:0] RST_IEN = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SENSE_LOW, SENSE_ANY, SENSE_FALL, SENSE_RISE} eis_sense_t;
  typedef enum logic [1:0] {WK_IDLE, WK_SAMPLE, WK_START} eis_wake_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } eis_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } eis_axi_rsp_t;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic [7:0] mcu_ctl;
    logic [1:0] en;
    logic [1:0] flag;
    logic [1:0] req;
    logic [EV_W-1:0] ist;
    logic [EV_W-1:0] ien;
    logic irq;
    eis_wake_t wk;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] wdt_cnt;
    logic wake;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    eis_axi_rsp_t rsp;
  } eis_state_t;

endpackage : eis_pkg

`default_nettype wire

// ### core/eis_top.sv
// Purpose: two-pin external interrupt sense, flags, wake-up and AXI4-Lite registers
// Assumes: pins are asynchronous; ack, sleep and global enable come from this clock
// Notes: low-level path never depends on io_run_i; edge paths stop with it
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none

module eis_top #(
  parameter int STARTUP_NS = 1000
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [1:0] pin_i,
  input wire logic io_run_i,
  input wire logic sleep_i,
  input wire logic gie_i,
  input wire logic [1:0] ack_i,
  input wire eis_pkg::eis_axi_req_t axi_req_i,
  output eis_pkg::eis_axi_rsp_t axi_rsp_o,
  output logic [1:0] req_o,
  output logic irq_o,
  output logic wake_o
);
  import eis_pkg::*;

  // ----------------------------------------------------------------
  // derived counts
  // ----------------------------------------------------------------
  localparam int STARTUP_RAW = (STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STARTUP_MIN = (STARTUP_RAW < 1) ? 1 : STARTUP_RAW;
  localparam logic [CNT_W-1:0] STARTUP_CYC = CNT_W'(STARTUP_MIN);
  localparam int WDT_RAW = (WDT_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int WDT_MIN = (WDT_RAW < 1) ? 1 : WDT_RAW;
  localparam logic [CNT_W-1:0] WDT_CYC = CNT_W'(WDT_MIN);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic eis_sense_t sense_of(input logic [7:0] ctl, input int pin);
    logic [1:0] code;
    code = 2'h0;
    if (pin == 1) begin
      code = ctl[SENSE_P1_LSB +: 2];
    end else begin
      code = ctl[SENSE_P0_LSB +: 2];
    end
    sense_of = eis_sense_t'(code);
  endfunction : sense_of

  function automatic logic edge_hit(input eis_sense_t mode, input logic old_v,
                                    input logic cur_v);
    logic hit;
    hit = 1'b0;
    case (mode)
      SENSE_ANY: begin
        hit = old_v ^ cur_v;
      end
      SENSE_FALL: begin
        hit = old_v & ~cur_v;
      end
      SENSE_RISE: begin
        hit = ~old_v & cur_v;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    edge_hit = hit;
  endfunction : edge_hit

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    is_mapped = (w == OFF_MCU_CTL) || (w == OFF_EN_CTL) || (w == OFF_FLAGS) ||
                (w == OFF_IST) || (w == OFF_ICLR) || (w == OFF_IEN) ||
                (w == OFF_PIN_STATE);
  endfunction : is_mapped

  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a,
                                          input eis_state_t s);
    logic [31:0] d;
    logic [7:0] w;
    d = 32'h0000_0000;
    w = {a[7:2], 2'b00};
    case (w)
      OFF_MCU_CTL: begin
        d[7:0] = s.mcu_ctl;
      end
      OFF_EN_CTL: begin
        d[EN_P0_BIT +: 2] = s.en;
      end
      OFF_FLAGS: begin
        d[FLAG_P0_BIT +: 2] = s.flag;
      end
      OFF_IST: begin
        d[EV_W-1:0] = s.ist;
      end
      OFF_IEN: begin
        d[EV_W-1:0] = s.ien;
      end
      OFF_PIN_STATE: begin
        d[PST_PIN_LSB +: 2] = s.sync2;
        d[PST_WAKE_BIT] = s.wake;
        d[PST_WK_LSB +: 2] = s.wk;
      end
      default: begin
        d = 32'h0000_0000;
      end
    endcase
    rd_word = d;
  endfunction : rd_word

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  eis_state_t r;
  eis_state_t n;
  eis_sense_t mode [2];
  logic [1:0] level_mode;
  logic [1:0] lvl_act;
  logic [1:0] ev;
  logic [1:0] clr_flag;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic wr_go;
  logic [7:0] wr_word;
  logic wr_lo;
  logic wdt_tick;
  logic any_lvl;
  logic wake_ev;

  always_comb begin
    n = r;
    mode[0] = sense_of(r.mcu_ctl, 0);
    mode[1] = sense_of(r.mcu_ctl, 1);
    level_mode = 2'b00;
    lvl_act = 2'b00;
    ev = 2'b00;
    clr_flag = 2'b00;
    ev_set = '0;
    ev_clr = '0;
    wake_ev = 1'b0;
    wdt_tick = 1'b0;
    wr_go = r.aw_have & r.w_have & ~r.rsp.bvalid;
    wr_word = {r.wr_addr[7:2], 2'b00};
    wr_lo = r.wr_strb[0];

    // ----------------------------------------------------------------
    // pin sampling and sense
    // ----------------------------------------------------------------
    // two-flop pin sync
    n.sync1 = pin_i;
    n.sync2 = r.sync1;
    if (io_run_i) begin
      n.prev = r.sync2;
    end
    for (int i = 0; i < 2; i++) begin
      level_mode[i] = (mode[i] == SENSE_LOW);
      lvl_act[i] = level_mode[i] & ~r.sync2[i];
      ev[i] = io_run_i & ~level_mode[i] & edge_hit(mode[i], r.prev[i], r.sync2[i]);
    end
    any_lvl = |(lvl_act & r.en);

    // ----------------------------------------------------------------
    // request flags
    // ----------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      clr_flag[i] = ack_i[i] |
                    (wr_go & wr_lo & (wr_word == OFF_FLAGS) & r.wr_data[FLAG_P0_BIT + i]);
      if (level_mode[i]) begin
        n.flag[i] = 1'b0;
      end else begin
        n.flag[i] = (r.flag[i] & ~clr_flag[i]) | ev[i];
      end
    end

    // ----------------------------------------------------------------
    // requests toward the CPU
    // ----------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      n.req[i] = gie_i & r.en[i] & (level_mode[i] ? lvl_act[i] : r.flag[i]);
    end
    if (r.wk == WK_START) begin
      n.req = 2'b00;
    end

    // ----------------------------------------------------------------
    // wake-up sampling
    // ----------------------------------------------------------------
    if (r.wdt_cnt == '0) begin
      n.wdt_cnt = WDT_CYC - 1'b1;
      wdt_tick = 1'b1;
    end else begin
      n.wdt_cnt = r.wdt_cnt - 1'b1;
    end
    if (!sleep_i && r.wk != WK_START) begin
      n.wake = 1'b0;
    end
    case (r.wk)
      WK_IDLE: begin
        if (sleep_i && wdt_tick && any_lvl) begin
          n.wk = WK_SAMPLE;
        end
      end
      WK_SAMPLE: begin
        if (!sleep_i) begin
          n.wk = WK_IDLE;
        end else if (wdt_tick) begin
          if (any_lvl) begin
            n.wake = 1'b1;
            wake_ev = 1'b1;
            n.cnt = STARTUP_CYC;
            n.wk = WK_START;
          end else begin
            n.wk = WK_IDLE;
          end
        end
      end
      WK_START: begin
        if (r.cnt == '0) begin
          n.wk = WK_IDLE;
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      default: begin
        n.wk = WK_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // event status and interrupt line
    // ----------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      ev_set[EV_P0 + i] = ev[i] | (lvl_act[i] & r.en[i]);
    end
    ev_set[EV_WAKE] = wake_ev;
    if (wr_go && wr_lo && wr_word == OFF_ICLR) begin
      ev_clr = r.wr_data[EV_W-1:0];
    end
    n.ist = (r.ist & ~ev_clr) | ev_set;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (wr_go && wr_lo) begin
      case (wr_word)
        OFF_MCU_CTL: begin
          n.mcu_ctl = r.wr_data[7:0];
        end
        OFF_EN_CTL: begin
          n.en = r.wr_data[EN_P0_BIT +: 2];
        end
        OFF_IEN: begin
          n.ien = r.wr_data[EV_W-1:0];
        end
        default: begin
          n.ien = r.ien;
        end
      endcase
    end
    n.irq = |(n.ist & n.ien);

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    if (axi_req_i.awvalid && r.rsp.awready) begin
      n.aw_have = 1'b1;
      n.wr_addr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && r.rsp.wready) begin
      n.w_have = 1'b1;
      n.wr_data = axi_req_i.wdata;
      n.wr_strb = axi_req_i.wstrb;
    end
    if (r.rsp.bvalid && axi_req_i.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = is_mapped(r.wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    n.rsp.awready = ~n.aw_have & ~n.rsp.bvalid;
    n.rsp.wready = ~n.w_have & ~n.rsp.bvalid;

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    if (r.rsp.rvalid && axi_req_i.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axi_req_i.arvalid && r.rsp.arready) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rdata = rd_word(axi_req_i.araddr, r);
      n.rsp.rresp = is_mapped(axi_req_i.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    n.rsp.arready = ~n.rsp.rvalid;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.mcu_ctl <= RST_MCU_CTL;
      r.en <= RST_EN;
      r.ien <= RST_IEN;
      r.wk <= WK_IDLE;
    end else if (ce_i) begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign axi_rsp_o = r.rsp;
  assign req_o = r.req;
  assign irq_o = r.irq;
  assign wake_o = r.wake;

endmodule : eis_top

`default_nettype wire

// ### sim/eis_pin_src.sv
// Purpose: outside signal source for the two request pins
// Assumes: pins idle high through a pull-up
// Notes: levels change just after a rising edge
`default_nettype none
module eis_pin_src (
  input wire logic clk_i,
  output var logic [1:0] pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pin_o = 2'h3;
  task automatic drive(input int idx, input logic v, input int n);
    pin_o[idx] <= v;
    repeat ((n < 2) ? 2 : n) @(posedge clk_i);
  endtask : drive
endmodule : eis_pin_src
`default_nettype wire

// ### sim/eis_monitor.sv
// Purpose: bus and request checks at the top ports
// Assumes: one clock, asynchronous active high reset
// Notes: bound to every eis_top
`default_nettype none
module eis_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [1:0] pin_i,
  input wire logic io_run_i,
  input wire logic sleep_i,
  input wire logic gie_i,
  input wire logic [1:0] ack_i,
  input wire eis_pkg::eis_axi_req_t axi_req_i,
  input wire eis_pkg::eis_axi_rsp_t axi_rsp_o,
  input wire logic [1:0] req_o,
  input wire logic irq_o,
  input wire logic wake_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import eis_pkg::*;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------
  // checks
  // ----------------
  a_req_gie: assert property (|req_o |-> $past(gie_i))
    else $error("request without global enable");
  a_wake_cause: assert property ($rose(wake_o) |-> $past(sleep_i) && !(&$past(pin_i, 3)))
    else $error("wake without low pin in sleep");
  a_b_after: assert property (axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid
    && axi_rsp_o.wready |-> ##2 axi_rsp_o.bvalid)
    else $error("write response late");
  a_r_after: assert property (axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
    else $error("read data late");
  a_b_once: assert property (axi_rsp_o.bvalid && axi_req_i.bready |=> !axi_rsp_o.bvalid)
    else $error("write response repeated");
  a_r_once: assert property (axi_rsp_o.rvalid && axi_req_i.rready |=> !axi_rsp_o.rvalid)
    else $error("read data repeated");
  a_ar_block: assert property (axi_rsp_o.rvalid |-> !axi_rsp_o.arready)
    else $error("read taken while data pending");
  a_w_block: assert property (axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready)
    else $error("write taken while response pending");
  a_read_unmapped: assert property (axi_req_i.arvalid && axi_rsp_o.arready
    && axi_req_i.araddr >= 8'h1C |=> axi_rsp_o.rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  a_ce_freeze: assert property (!ce_i |=> $stable(req_o) && $stable(irq_o) && $stable(wake_o))
    else $error("outputs moved while clock enable low");
  c_wake: cover property ($rose(wake_o));
  c_irq: cover property ($rose(irq_o));
  c_req1: cover property ($rose(req_o[1]));
endmodule : eis_monitor

bind eis_top eis_monitor u_mon (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .pin_i(pin_i), .io_run_i(io_run_i),
  .sleep_i(sleep_i), .gie_i(gie_i), .ack_i(ack_i), .axi_req_i(axi_req_i),
  .axi_rsp_o(axi_rsp_o), .req_o(req_o), .irq_o(irq_o), .wake_o(wake_o)
);
`default_nettype wire

// ### sim/test_external_interrupt_sense.sv
// Purpose: register and pin tests of the external interrupt sense block
// Assumes: pins idle high, driven by the pin source model
// Notes: start-up shortened to four cycles
`default_nettype none
module test_external_interrupt_sense;
  timeunit 1ns;
  timeprecision 100ps;
  import eis_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic gie = 1'b0;
  logic sleep = 1'b0;
  logic io_run = 1'b1;
  logic ce = 1'b1;
  logic [1:0] ack = 2'h0;
  logic [1:0] pin, req;
  logic irq, wake;
  eis_axi_req_t axi_req = '0;
  eis_axi_rsp_t axi_rsp;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  eis_pin_src u_src (.clk_i(clk), .pin_o(pin));
  eis_top #(.STARTUP_NS(100)) u_eis_top (.ref_clk_i(clk), .rst_i(rst), .ce_i(ce),
    .pin_i(pin), .io_run_i(io_run), .sleep_i(sleep), .gie_i(gie), .ack_i(ack),
    .axi_req_i(axi_req), .axi_rsp_o(axi_rsp), .req_o(req), .irq_o(irq), .wake_o(wake));
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && axi_rsp.awready === 1'b1) begin
        aw = 1'b1;
        axi_req.awvalid <= 1'b0;
      end
      if (!w && axi_rsp.wready === 1'b1) begin
        w = 1'b1;
        axi_req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (axi_rsp.bvalid !== 1'b1);
    axi_req.bready <= 1'b0;
    chk("bresp", 32'(er), 32'(axi_rsp.bresp));
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    do @(posedge clk); while (axi_rsp.arready !== 1'b1);
    axi_req.arvalid <= 1'b0;
    do @(posedge clk); while (axi_rsp.rvalid !== 1'b1);
    axi_req.rready <= 1'b0;
    chk("rdata", e, axi_rsp.rdata);
    chk("rresp", 32'(er), 32'(axi_rsp.rresp));
  endtask : rc
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    int p, m, i;
    logic [7:0] regs [4];
    regs = '{OFF_MCU_CTL, OFF_EN_CTL, OFF_FLAGS, OFF_IEN};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) rc(regs[i], 32'h0, RESP_OKAY);
    rc(8'h1C, 32'h0, RESP_SLVERR);
    rc(OFF_PIN_STATE, 32'h3, RESP_OKAY);
    wr(8'h20, 32'hFF, RESP_SLVERR);
    $display("test reset done");
    gie <= 1'b1;
    for (p = 0; p < 2; p++) begin
      wr(OFF_EN_CTL, 32'h40 << p, RESP_OKAY);
      for (m = 1; m < 4; m++) begin
        wr(OFF_MCU_CTL, 32'(m) << (2 * p), RESP_OKAY);
        u_src.drive(p, 1'b0, 4);
        rc(OFF_FLAGS, 32'(m != 3) << (6 + p), RESP_OKAY);
        chk("req", 32'(m != 3), 32'(req[p]));
        wr(OFF_FLAGS, 32'hC0, RESP_OKAY);
        u_src.drive(p, 1'b1, 4);
        rc(OFF_FLAGS, 32'(m != 2) << (6 + p), RESP_OKAY);
        ack <= 2'(1 << p);
        @(posedge clk);
        ack <= 2'h0;
        rc(OFF_FLAGS, 32'h0, RESP_OKAY);
      end
    end
    $display("test edge done");
    wr(OFF_MCU_CTL, 32'h0, RESP_OKAY);
    for (p = 0; p < 2; p++) begin
      wr(OFF_EN_CTL, 32'h40 << p, RESP_OKAY);
      u_src.drive(p, 1'b0, 20);
      chk("level req", 32'h1, 32'(req[p]));
      rc(OFF_FLAGS, 32'h0, RESP_OKAY);
      gie <= 1'b0;
      repeat (2) @(posedge clk);
      chk("req no gie", 32'h0, 32'(req[p]));
      gie <= 1'b1;
      ack <= 2'(1 << p);
      @(posedge clk);
      ack <= 2'h0;
      u_src.drive(p, 1'b1, 5);
      chk("level off", 32'h0, 32'(req[p]));
    end
    $display("test level done");
    wr(OFF_ICLR, 32'h7, RESP_OKAY);
    wr(OFF_MCU_CTL, 32'h2, RESP_OKAY);
    wr(OFF_EN_CTL, 32'h40, RESP_OKAY);
    wr(OFF_IEN, 32'h1, RESP_OKAY);
    u_src.drive(0, 1'b0, 4);
    chk("irq", 32'h1, 32'(irq));
    wr(OFF_IEN, 32'h0, RESP_OKAY);
    rc(OFF_IST, 32'h1, RESP_OKAY);
    chk("irq masked", 32'h0, 32'(irq));
    wr(OFF_IEN, 32'h1, RESP_OKAY);
    wr(OFF_ICLR, 32'h7, RESP_OKAY);
    rc(OFF_IST, 32'h0, RESP_OKAY);
    chk("irq cleared", 32'h0, 32'(irq));
    rc(OFF_ICLR, 32'h0, RESP_OKAY);
    rc(OFF_IEN, 32'h1, RESP_OKAY);
    u_src.drive(0, 1'b1, 2);
    wr(OFF_FLAGS, 32'hC0, RESP_OKAY);
    $display("test irq done");
    // clock enable freezes sync and flags
    ce <= 1'b0;
    u_src.drive(0, 1'b0, 4);
    chk("ce hold", 32'h0, 32'(req));
    ce <= 1'b1;
    repeat (5) @(posedge clk);
    chk("ce run", 32'h1, 32'(req[0]));
    u_src.drive(0, 1'b1, 2);
    wr(OFF_FLAGS, 32'hC0, RESP_OKAY);
    wr(OFF_ICLR, 32'h7, RESP_OKAY);
    $display("test enable done");
    io_run <= 1'b0;
    wr(OFF_MCU_CTL, 32'h8, RESP_OKAY);
    wr(OFF_EN_CTL, 32'h80, RESP_OKAY);
    u_src.drive(1, 1'b0, 4);
    u_src.drive(1, 1'b1, 4);
    rc(OFF_FLAGS, 32'h0, RESP_OKAY);
    gie <= 1'b0;
    sleep <= 1'b1;
    wr(OFF_MCU_CTL, 32'h0, RESP_OKAY);
    u_src.drive(1, 1'b0, 2);
    for (i = 0; i < 200 && wake !== 1'b1; i++) @(posedge clk);
    chk("wake", 32'h1, 32'(wake));
    gie <= 1'b1;
    u_src.drive(1, 1'b1, 2);
    for (i = 0; i < 12; i++) begin
      @(posedge clk);
      chk("wake req", 32'h0, 32'(req));
    end
    sleep <= 1'b0;
    io_run <= 1'b1;
    repeat (12) @(posedge clk);
    chk("wake off", 32'h0, 32'(wake));
    $display("test wake done");
    print_verdict();
  end
endmodule : test_external_interrupt_sense
`default_nettype wire
